// ---- sbcp_pkg.sv ----
package sbcp_pkg;

  // ****************************************************************
  // Register map (byte addresses, one aligned word each)
  // ****************************************************************
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] LEN_OFF = 8'h04;
  localparam logic [7:0] KEY_OFF = 8'h08;
  localparam logic [7:0] STAT_OFF = 8'h0C;
  localparam logic [7:0] IRQ_STAT_OFF = 8'h10;
  localparam logic [7:0] IRQ_EN_OFF = 8'h14;
  localparam logic [7:0] IRQ_CLR_OFF = 8'h18;
  localparam logic [7:0] RX_CNT_OFF = 8'h1C;

  // Control fields
  localparam int CTRL_COMPRESS_BIT = 0;
  localparam int CTRL_DECRYPT_BIT = 1;
  localparam int CTRL_RESTART_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h4;
  localparam logic [31:0] LEN_RESET = 32'h0000_0400;
  localparam logic [31:0] KEY_RESET = 32'h0000_0000;

  // Interrupt event bits
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_ERROR_BIT = 1;
  localparam int IRQ_USER_BIT = 2;
  localparam int IRQ_W = 3;

  // Strap code that picks the host-driven scheme
  localparam logic [2:0] STRAP_HOST_DRIVEN = 3'h2;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ = 100;
  localparam int FLASH_SCLK_MHZ = 25;
  localparam int FLASH_DIV = CLK_MHZ / FLASH_SCLK_MHZ;
  localparam logic [1:0] FLASH_DIV_LAST = 2'(FLASH_DIV - 1);
  localparam logic [1:0] FLASH_DIV_HALF = 2'(FLASH_DIV / 2);
  localparam int INIT_MIN_US = 20;
  localparam logic [13:0] INIT_CYCLES = 14'(INIT_MIN_US * CLK_MHZ);
  localparam int RESTART_MAX_US = 100;
  localparam int RESTART_CYCLES_DEF = RESTART_MAX_US * CLK_MHZ;
  localparam int TIMER_W = 14;

  // Compression: a 0 token stands for this many zeros, a 1 token
  // announces this many literal bits
  localparam logic [2:0] RUN_LEN = 3'h4;

  // Synchroniser reset value: request asserted, chip select high
  localparam int SYNC_W = 12;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 12'h002;

  typedef enum logic [2:0] {
    ST_RESET,
    ST_LOAD,
    ST_INIT,
    ST_USER,
    ST_ERROR
  } sbcp_state_e;

  typedef struct packed {
    logic sclk_out;
    logic sclk_oe;
    logic sel_n;
    logic sel_oe;
    logic mosi;
    logic mosi_oe;
  } sbcp_flash_s;

  typedef struct packed {
    logic bit_val;
    logic valid;
  } sbcp_stream_s;

endpackage

// ---- sbcp_sync.sv ----
`timescale 1ns/1ns
module sbcp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= RST_VAL;
      q_reg <= RST_VAL;
    end
    else
    begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end

  assign q = q_reg;

endmodule // sbcp_sync

// ---- sbcp_top.sv ----
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/1ns
module sbcp_top #(
  parameter int RESTART_CYCLES = sbcp_pkg::RESTART_CYCLES_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic config_request_n,
  input wire logic chip_select_in_n,
  input wire logic [2:0] mode_strap_pins,
  input wire logic config_serial_clock_in,
  input wire logic serial_config_data,
  input wire logic config_status_n_in,
  output logic config_status_n_out,
  output logic config_status_n_oe,
  input wire logic config_complete_in,
  output logic config_complete_out,
  output logic config_complete_oe,
  output sbcp_pkg::sbcp_flash_s flash,
  input wire logic bridge_en,
  input wire logic bridge_sclk,
  input wire logic bridge_sel_n,
  input wire logic bridge_mosi,
  output logic bridge_miso,
  input wire logic frame_error,
  output sbcp_pkg::sbcp_stream_s cfg_stream,
  output logic user_mode,
  output logic irq
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [sbcp_pkg::SYNC_W-1:0] pins_sync;
  logic req_n_s;
  logic cs_n_s;
  logic [2:0] strap_s;
  logic sclk_s;
  logic data_s;
  logic complete_s;
  logic br_en_s;
  logic br_sclk_s;
  logic br_sel_n_s;
  logic br_mosi_s;

  sbcp_sync #(
    .W(sbcp_pkg::SYNC_W),
    .RST_VAL(sbcp_pkg::SYNC_RESET)
  ) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d({bridge_mosi, bridge_sel_n, bridge_sclk, bridge_en, config_complete_in,
        serial_config_data, config_serial_clock_in, mode_strap_pins, chip_select_in_n,
        config_request_n}),
    .q(pins_sync)
  );

  assign req_n_s = pins_sync[0];
  assign cs_n_s = pins_sync[1];
  assign strap_s = pins_sync[4:2];
  assign sclk_s = pins_sync[5];
  assign data_s = pins_sync[6];
  assign complete_s = pins_sync[7];
  assign br_en_s = pins_sync[8];
  assign br_sclk_s = pins_sync[9];
  assign br_sel_n_s = pins_sync[10];
  assign br_mosi_s = pins_sync[11];

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [2:0] ctrl_reg, ctrl_next;
  logic [31:0] len_reg, len_next;
  logic [31:0] key_reg, key_next;
  logic [sbcp_pkg::IRQ_W-1:0] irq_stat_reg, irq_stat_next;
  logic [sbcp_pkg::IRQ_W-1:0] irq_en_reg, irq_en_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pslverr_reg, pslverr_next;

  // ****************************************************************
  // Configuration state
  // ****************************************************************
  sbcp_pkg::sbcp_state_e state_reg, state_next;
  logic host_mode_reg, host_mode_next;
  logic [1:0] div_reg, div_next;
  logic [sbcp_pkg::TIMER_W-1:0] timer_reg, timer_next;
  logic [31:0] bit_cnt_reg, bit_cnt_next;
  logic [31:0] rx_cnt_reg, rx_cnt_next;
  logic [2:0] zero_cnt_reg, zero_cnt_next;
  logic [2:0] lit_cnt_reg, lit_cnt_next;
  logic [4:0] key_idx_reg, key_idx_next;
  logic sclk_prev_reg, sclk_prev_next;
  sbcp_pkg::sbcp_stream_s stream_reg, stream_next;
  sbcp_pkg::sbcp_flash_s flash_reg, flash_next;
  logic miso_reg, miso_next;
  logic [sbcp_pkg::IRQ_W-1:0] events;

  logic setup_ph;
  logic wr_acc;
  logic rx_valid;
  logic as_active;
  logic emit;
  logic emit_bit;

  assign setup_ph = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;

  // ****************************************************************
  // APB slave: zero wait states, read data captured in setup
  // ****************************************************************
  always_comb
  begin
    ctrl_next = ctrl_reg;
    len_next = len_reg;
    key_next = key_reg;
    irq_en_next = irq_en_reg;
    prdata_next = prdata_reg;
    pslverr_next = 1'b0;
    if (wr_acc)
    begin
      if (paddr == sbcp_pkg::CTRL_OFF)
        ctrl_next = pwdata[2:0];
      else if (paddr == sbcp_pkg::LEN_OFF)
        len_next = pwdata;
      else if (paddr == sbcp_pkg::KEY_OFF)
        key_next = pwdata;
      else if (paddr == sbcp_pkg::IRQ_EN_OFF)
        irq_en_next = pwdata[sbcp_pkg::IRQ_W-1:0];
    end
    if (setup_ph)
    begin
      prdata_next = 32'h0000_0000;
      if (paddr == sbcp_pkg::CTRL_OFF)
        prdata_next = {29'h0000_0000, ctrl_reg};
      else if (paddr == sbcp_pkg::LEN_OFF)
        prdata_next = len_reg;
      else if (paddr == sbcp_pkg::KEY_OFF)
        prdata_next = key_reg;
      else if (paddr == sbcp_pkg::STAT_OFF)
        prdata_next = {24'h00_0000, strap_s, cs_n_s, host_mode_reg, state_reg};
      else if (paddr == sbcp_pkg::IRQ_STAT_OFF)
        prdata_next = {29'h0000_0000, irq_stat_reg};
      else if (paddr == sbcp_pkg::IRQ_EN_OFF)
        prdata_next = {29'h0000_0000, irq_en_reg};
      else if (paddr == sbcp_pkg::IRQ_CLR_OFF)
        prdata_next = 32'h0000_0000;
      else if (paddr == sbcp_pkg::RX_CNT_OFF)
        prdata_next = rx_cnt_reg;
      else
        pslverr_next = 1'b1;
    end
    else
      pslverr_next = pslverr_reg;
    // Set wins over clear
    irq_stat_next = irq_stat_reg;
    if (wr_acc && paddr == sbcp_pkg::IRQ_CLR_OFF)
      irq_stat_next = irq_stat_next & ~pwdata[sbcp_pkg::IRQ_W-1:0];
    irq_stat_next = irq_stat_next | events;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg <= sbcp_pkg::CTRL_RESET;
      len_reg <= sbcp_pkg::LEN_RESET;
      key_reg <= sbcp_pkg::KEY_RESET;
      irq_stat_reg <= '0;
      irq_en_reg <= '0;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      len_reg <= len_next;
      key_reg <= key_next;
      irq_stat_reg <= irq_stat_next;
      irq_en_reg <= irq_en_next;
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign pready = psel & penable;
  assign prdata = prdata_reg;
  assign pslverr = pready & pslverr_reg;
  assign irq = |(irq_stat_reg & irq_en_reg);

  // ****************************************************************
  // Serial capture, expansion and sequencing
  // ****************************************************************
  assign as_active = (state_reg == sbcp_pkg::ST_LOAD) & ~host_mode_reg & ~cs_n_s;

  always_comb
  begin
    state_next = state_reg;
    host_mode_next = host_mode_reg;
    div_next = div_reg;
    timer_next = timer_reg;
    bit_cnt_next = bit_cnt_reg;
    rx_cnt_next = rx_cnt_reg;
    zero_cnt_next = zero_cnt_reg;
    lit_cnt_next = lit_cnt_reg;
    key_idx_next = key_idx_reg;
    sclk_prev_next = sclk_s;
    stream_next = '0;
    flash_next = '0;
    flash_next.sel_n = 1'b1;
    miso_next = data_s;
    events = '0;
    rx_valid = 1'b0;
    emit = 1'b0;
    emit_bit = 1'b0;
    // Flash-master clock: one bit per divided period, taken before the fall
    if (as_active)
    begin
      div_next = (div_reg == sbcp_pkg::FLASH_DIV_LAST) ? 2'h0 : div_reg + 2'h1;
      flash_next.sclk_out = (div_next >= sbcp_pkg::FLASH_DIV_HALF);
      flash_next.sclk_oe = 1'b1;
      flash_next.sel_n = 1'b0;
      flash_next.sel_oe = 1'b1;
      flash_next.mosi_oe = 1'b1;
      rx_valid = (div_reg == sbcp_pkg::FLASH_DIV_LAST);
    end
    else
    begin
      div_next = 2'h0;
      if (state_reg == sbcp_pkg::ST_LOAD && host_mode_reg)
        rx_valid = sclk_s & ~sclk_prev_reg;
      if (br_en_s && !cs_n_s && state_reg != sbcp_pkg::ST_LOAD)
      begin
        flash_next.sclk_out = br_sclk_s;
        flash_next.sclk_oe = 1'b1;
        flash_next.sel_n = br_sel_n_s;
        flash_next.sel_oe = 1'b1;
        flash_next.mosi = br_mosi_s;
        flash_next.mosi_oe = 1'b1;
      end
    end
    if (rx_valid)
      rx_cnt_next = rx_cnt_reg + 32'h1;
    // Expander: zero runs, literal groups or plain pass-through
    if (zero_cnt_reg != 3'h0)
    begin
      emit = 1'b1;
      zero_cnt_next = zero_cnt_reg - 3'h1;
    end
    else if (rx_valid)
    begin
      if (!ctrl_reg[sbcp_pkg::CTRL_COMPRESS_BIT] || lit_cnt_reg != 3'h0)
      begin
        emit = 1'b1;
        emit_bit = data_s;
        if (lit_cnt_reg != 3'h0)
          lit_cnt_next = lit_cnt_reg - 3'h1;
      end
      else if (!data_s)
      begin
        emit = 1'b1;
        zero_cnt_next = sbcp_pkg::RUN_LEN - 3'h1;
      end
      else
        lit_cnt_next = sbcp_pkg::RUN_LEN;
    end
    if (emit)
    begin
      stream_next.valid = 1'b1;
      stream_next.bit_val = emit_bit ^ (ctrl_reg[sbcp_pkg::CTRL_DECRYPT_BIT] & key_reg[key_idx_reg]);
      key_idx_next = key_idx_reg + 5'h1;
      bit_cnt_next = bit_cnt_reg + 32'h1;
    end
    case (state_reg)
      sbcp_pkg::ST_RESET:
      begin
        if (req_n_s)
        begin
          host_mode_next = (strap_s == sbcp_pkg::STRAP_HOST_DRIVEN);
          state_next = sbcp_pkg::ST_LOAD;
        end
      end
      sbcp_pkg::ST_LOAD:
      begin
        if (frame_error)
        begin
          state_next = sbcp_pkg::ST_ERROR;
          timer_next = '0;
          events[sbcp_pkg::IRQ_ERROR_BIT] = 1'b1;
        end
        else if (emit && bit_cnt_next >= len_reg)
        begin
          state_next = sbcp_pkg::ST_INIT;
          timer_next = '0;
          events[sbcp_pkg::IRQ_DONE_BIT] = 1'b1;
        end
      end
      sbcp_pkg::ST_INIT:
      begin
        if (!complete_s)
          timer_next = '0;
        else if (timer_reg == sbcp_pkg::INIT_CYCLES - 14'h1)
        begin
          state_next = sbcp_pkg::ST_USER;
          events[sbcp_pkg::IRQ_USER_BIT] = 1'b1;
        end
        else
          timer_next = timer_reg + 14'h1;
      end
      sbcp_pkg::ST_USER:
      begin
        state_next = sbcp_pkg::ST_USER;
      end
      sbcp_pkg::ST_ERROR:
      begin
        if (ctrl_reg[sbcp_pkg::CTRL_RESTART_BIT])
        begin
          if (timer_reg == sbcp_pkg::TIMER_W'(RESTART_CYCLES - 1))
            state_next = sbcp_pkg::ST_LOAD;
          else
            timer_next = timer_reg + 14'h1;
        end
      end
      default:
        state_next = sbcp_pkg::ST_RESET;
    endcase
    // Leaving the load phase drops any half-expanded token
    if (state_next != sbcp_pkg::ST_LOAD || state_reg != sbcp_pkg::ST_LOAD)
    begin
      zero_cnt_next = 3'h0;
      lit_cnt_next = 3'h0;
    end
    if (state_reg != sbcp_pkg::ST_LOAD && state_next == sbcp_pkg::ST_LOAD)
    begin
      bit_cnt_next = 32'h0;
      rx_cnt_next = 32'h0;
      key_idx_next = 5'h0;
    end
    if (!req_n_s)
    begin
      state_next = sbcp_pkg::ST_RESET;
      timer_next = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= sbcp_pkg::ST_RESET;
      host_mode_reg <= 1'b0;
      div_reg <= 2'h0;
      timer_reg <= '0;
      bit_cnt_reg <= 32'h0;
      rx_cnt_reg <= 32'h0;
      zero_cnt_reg <= 3'h0;
      lit_cnt_reg <= 3'h0;
      key_idx_reg <= 5'h0;
      sclk_prev_reg <= 1'b0;
      stream_reg <= '0;
      flash_reg <= 6'h08;
      miso_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      host_mode_reg <= host_mode_next;
      div_reg <= div_next;
      timer_reg <= timer_next;
      bit_cnt_reg <= bit_cnt_next;
      rx_cnt_reg <= rx_cnt_next;
      zero_cnt_reg <= zero_cnt_next;
      lit_cnt_reg <= lit_cnt_next;
      key_idx_reg <= key_idx_next;
      sclk_prev_reg <= sclk_prev_next;
      stream_reg <= stream_next;
      flash_reg <= flash_next;
      miso_reg <= miso_next;
    end
  end

  // ****************************************************************
  // Open-drain pins and outputs
  // ****************************************************************
  assign config_status_n_out = 1'b0;
  assign config_status_n_oe = (state_reg == sbcp_pkg::ST_RESET) |
                              (state_reg == sbcp_pkg::ST_ERROR);
  assign config_complete_out = 1'b0;
  assign config_complete_oe = (state_reg != sbcp_pkg::ST_INIT) &
                              (state_reg != sbcp_pkg::ST_USER);
  assign flash = flash_reg;
  assign cfg_stream = stream_reg;
  assign bridge_miso = miso_reg;
  assign user_mode = (state_reg == sbcp_pkg::ST_USER);

endmodule // sbcp_top

// ---- sbcp_assertions.sv ----
`timescale 1ns/1ns
module sbcp_assertions (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pready,
  input logic pslverr,
  input logic config_request_n,
  input logic chip_select_in_n,
  input logic config_status_n_oe,
  input logic config_complete_in,
  input logic config_complete_oe,
  input sbcp_pkg::sbcp_flash_s flash,
  input logic bridge_en,
  input logic frame_error,
  input logic user_mode
);
  // ********
  // Checks
  // ********
  logic [13:0] hi_reg;
  logic [13:0] hi_next;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Cycles the complete line has stood high, saturating
  always_comb hi_next = !config_complete_in ? 14'h0000 : hi_reg + 14'(~&hi_reg);
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      hi_reg <= 14'h0000;
    else
      hi_reg <= hi_next;
  apb_ready_a: assert property (psel && penable |-> pready)
    else $error("pready missing in access cycle");
  slverr_gated_a: assert property (pslverr |-> pready)
    else $error("pslverr outside access cycle");
  status_release_a: assert property ($rose(config_request_n) |-> ##[1:10] !config_status_n_oe)
    else $error("status not released after request");
  reset_hold_a: assert property (!config_request_n [*5] |-> config_status_n_oe && !user_mode)
    else $error("left reset while request low");
  flash_idle_a: assert property ((chip_select_in_n && !bridge_en) [*5] |->
    !flash.sclk_oe && !flash.sel_oe && !flash.mosi_oe)
    else $error("flash pins driven while chip select high");
  sclk_high_a: assert property ($rose(flash.sclk_out) && !bridge_en |=>
    flash.sclk_out ##1 !flash.sclk_out)
    else $error("serial clock high time wrong");
  sclk_low_a: assert property ($fell(flash.sclk_out) && !bridge_en |-> !flash.sclk_out [*2])
    else $error("serial clock low time too short");
  user_delay_a: assert property ($rose(user_mode) |->
    hi_reg >= 14'h07D0 && hi_reg <= 14'h2710)
    else $error("user mode delay out of range");
  error_drive_a: assert property (frame_error && !config_status_n_oe && config_complete_oe |=>
    ##[0:3] config_status_n_oe)
    else $error("status not driven after error");
endmodule // sbcp_assertions

bind sbcp_top sbcp_assertions u_sbcp_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
  .config_request_n, .chip_select_in_n, .config_status_n_oe, .config_complete_in,
  .config_complete_oe, .flash, .bridge_en, .frame_error, .user_mode);

// ---- sbcp_flash_model.sv ----
`timescale 1ns/1ns
module sbcp_flash_model #(
  parameter logic [31:0] IMAGE = 32'h0000_0001
) (
  input sbcp_pkg::sbcp_flash_s flash,
  output logic data
);
  logic [4:0] idx;
  initial idx = 5'h00;
  // Next bit after each falling serial clock while selected
  always @(negedge flash.sclk_out)
    if (flash.sel_oe && !flash.sel_n)
      idx <= idx + 5'h01;
  always @(negedge flash.sel_n)
    idx <= 5'h00;
  // Deselected line shows the inverse, never a stale bit
  assign data = (flash.sel_oe && !flash.sel_n) ? IMAGE[idx] : !IMAGE[idx];
endmodule // sbcp_flash_model

// ---- serial_bitstream_config_port_tb.sv ----
`timescale 1ns/1ns
module serial_bitstream_config_port_tb;
  localparam int RST_N = 20;
  localparam logic [31:0] IMAGE = 32'h5A3C_96E1;
  typedef struct {logic [7:0] a; logic [31:0] v; logic e;} sbcp_row_s;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, cap;
  logic req_n, cs_n, hclk, hdat, fdat, ferr, st_oe, cd_oe, user_mode, irq;
  logic br_en, br_sclk, br_sel_n, br_mosi, br_miso;
  logic [2:0] strap;
  sbcp_pkg::sbcp_flash_s flash;
  sbcp_pkg::sbcp_stream_s strm;
  int failures, n_compared, ncap, k;
  wire sdata = (strap === sbcp_pkg::STRAP_HOST_DRIVEN) ? hdat : fdat;
  sbcp_row_s rows [7] = '{
    '{sbcp_pkg::CTRL_OFF, 32'(sbcp_pkg::CTRL_RESET), 1'h0},
    '{sbcp_pkg::LEN_OFF, sbcp_pkg::LEN_RESET, 1'h0},
    '{sbcp_pkg::KEY_OFF, sbcp_pkg::KEY_RESET, 1'h0},
    '{sbcp_pkg::IRQ_STAT_OFF, 32'h0, 1'h0},
    '{sbcp_pkg::IRQ_EN_OFF, 32'h0, 1'h0},
    '{sbcp_pkg::RX_CNT_OFF, 32'h0, 1'h0},
    '{8'h20, 32'h0, 1'h1}};

  sbcp_top #(.RESTART_CYCLES(RST_N)) DUT (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .config_request_n(req_n),
    .chip_select_in_n(cs_n), .mode_strap_pins(strap), .config_serial_clock_in(hclk),
    .serial_config_data(sdata), .config_status_n_in(!st_oe), .config_status_n_out(),
    .config_status_n_oe(st_oe), .config_complete_in(!cd_oe), .config_complete_out(),
    .config_complete_oe(cd_oe), .flash, .bridge_en(br_en), .bridge_sclk(br_sclk),
    .bridge_sel_n(br_sel_n), .bridge_mosi(br_mosi), .bridge_miso(br_miso),
    .frame_error(ferr), .cfg_stream(strm), .user_mode, .irq);
  sbcp_flash_model #(.IMAGE(IMAGE)) u_flash (.flash(flash), .data(fdat));

  initial
  begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk)
    if (strm.valid === 1'h1)
    begin
      cap[ncap[4:0]] <= strm.bit_val;
      ncap <= ncap + 1;
    end

  // ********
  // Tasks
  // ********
  task automatic print_verdict;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'h1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 50)
    begin
      failures++;
      print_verdict();
    end
    @(posedge pclk);
  endtask

  task automatic till(input int s, input int n);
    for (k = 0; k < n; k++)
    begin
      if (s == 0 && cd_oe === 1'h0 || s == 1 && user_mode === 1'h1 || s == 2 && st_oe === 1'h0)
        return;
      @(posedge pclk);
    end
    failures++;
    print_verdict();
  endtask

  task automatic start(input logic [2:0] s, input logic c);
    req_n <= 1'h0;
    repeat (8) @(posedge pclk);
    chk({user_mode, st_oe}, 32'h1);
    strap <= s;
    cs_n <= c;
    ncap = 0;
    @(posedge pclk);
    req_n <= 1'h1;
    till(2, 20);
  endtask

  task automatic host_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++)
    begin
      hdat <= b[i];
      repeat (4) @(posedge pclk);
      hclk <= 1'h1;
      repeat (4) @(posedge pclk);
      hclk <= 1'h0;
    end
  endtask

  // ********
  // Sequence
  // ********
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, ferr, hclk, hdat} = '0;
    {req_n, cs_n, strap, br_en, br_sclk, br_mosi} = '0;
    br_sel_n = 1'h1;
    {failures, n_compared, ncap} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    foreach (rows[i])
    begin
      apb(1'h0, rows[i].a, 32'h0);
      chk(rd, rows[i].v);
      chk(er, rows[i].e);
    end
    apb(1'h1, sbcp_pkg::LEN_OFF, 32'h10);
    apb(1'h1, sbcp_pkg::CTRL_OFF, 32'h0);
    apb(1'h1, sbcp_pkg::IRQ_EN_OFF, 32'h7);
    start(3'h0, 1'h1);
    repeat (100) @(posedge pclk);
    chk({flash.sclk_oe, flash.sel_oe, flash.mosi_oe}, 32'h0);
    chk(ncap, 32'h0);
    start(3'h0, 1'h0);
    till(0, 2000);
    @(posedge pclk);
    chk(cap[15:0], IMAGE[15:0]);
    chk(ncap, 32'h10);
    till(1, 12000);
    chk(k >= 2000 && k <= 10000, 32'h1);
    apb(1'h0, sbcp_pkg::IRQ_STAT_OFF, 32'h0);
    chk(rd, 32'h5);
    chk(irq, 32'h1);
    apb(1'h1, sbcp_pkg::IRQ_EN_OFF, 32'h2);
    @(posedge pclk);
    chk(irq, 32'h0);
    apb(1'h1, sbcp_pkg::IRQ_CLR_OFF, 32'h7);
    apb(1'h1, sbcp_pkg::IRQ_EN_OFF, 32'h7);
    @(posedge pclk);
    chk(irq, 32'h0);
    req_n <= 1'h0;
    {br_en, br_sclk, br_sel_n, br_mosi} <= 4'hD;
    repeat (8) @(posedge pclk);
    chk({flash.sclk_out, flash.sel_n, flash.mosi, flash.sclk_oe}, 32'hB);
    chk(br_miso, IMAGE[0]);
    br_sclk <= 1'h0;
    repeat (4) @(posedge pclk);
    {br_en, br_sel_n} <= 2'h1;
    apb(1'h1, sbcp_pkg::LEN_OFF, 32'h8);
    apb(1'h1, sbcp_pkg::KEY_OFF, 32'hA5);
    apb(1'h1, sbcp_pkg::CTRL_OFF, 32'h7);
    start(sbcp_pkg::STRAP_HOST_DRIVEN, 1'h0);
    ferr <= 1'h1;
    @(posedge pclk);
    ferr <= 1'h0;
    repeat (3) @(posedge pclk);
    chk(st_oe, 32'h1);
    till(2, RST_N + 10);
    apb(1'h0, sbcp_pkg::IRQ_STAT_OFF, 32'h0);
    chk(rd[1], 32'h1);
    host_byte(8'h36);
    till(0, 200);
    @(posedge pclk);
    chk(cap[7:0], 32'h75);
    apb(1'h0, sbcp_pkg::STAT_OFF, 32'h0);
    chk(rd[7:3], 32'h9);
    apb(1'h0, sbcp_pkg::RX_CNT_OFF, 32'h0);
    chk(rd, 32'h6);
    print_verdict();
  end
endmodule // serial_bitstream_config_port_tb
